// [design/ash_regs.svh]
// timing counts, field widths and reset values for the status/hold control
// assumes a 100 MHz reference clock
`ifndef ASH_REGS_SVH
`define ASH_REGS_SVH

`define ASH_CLK_PERIOD_NS  10
`define ASH_RST_HOLD_US    512
`define ASH_HIZ_US         800
`define ASH_STAB_MS        3
`define ASH_SAMPLE_US      16
`define ASH_RST_HOLD_CYC   ((`ASH_RST_HOLD_US * 1000) / `ASH_CLK_PERIOD_NS)
`define ASH_HIZ_CYC        ((`ASH_HIZ_US * 1000) / `ASH_CLK_PERIOD_NS)
`define ASH_STAB_CYC       ((`ASH_STAB_MS * 1000000) / `ASH_CLK_PERIOD_NS)
`define ASH_SAMPLE_CYC     ((`ASH_SAMPLE_US * 1000) / `ASH_CLK_PERIOD_NS)
`define ASH_AXIS_W         16
`define ASH_CNT_W          20
`define ASH_ST_OFFSET      16'h0100
`define ASH_STATUS_RST     1'b1
`define ASH_PIN_IDX_RSTN   0
`define ASH_PIN_IDX_SCLK   1
`define ASH_PIN_IDX_ST     2
`define ASH_PIN_IDX_FRZ    3

`endif

// [design/ash_pkg.sv]
// types shared by the status/hold control
// assumes ash_regs.svh is on the include path
`include "ash_regs.svh"
package ash_pkg;

    typedef enum logic [2:0]
    {
        ASH_ST_HIZ  = 3'b001,
        ASH_ST_STAB = 3'b010,
        ASH_ST_RUN  = 3'b100
    } ash_state_e;

    typedef struct packed
    {
        logic signed [`ASH_AXIS_W-1:0] x;
        logic signed [`ASH_AXIS_W-1:0] y;
    } ash_sample_s;

    typedef struct packed
    {
        logic parity;
        logic over_temp;
        logic clk_freq;
        logic terminal;
    } ash_fault_s;

endpackage

// [design/ash_ctrl.sv]
// reset detector, status latch, self-test and sample freeze control
// assumes fault flags, sample data and mode come from same-clock logic
// Notes on behaviour
// - reset needs reset low, sclk high 512us
// - faults, reset, initialization set status latch
// - status undriven about 800us, then high
// - 3ms stabilization starts when status rises
// - clears ignored during stabilization delay
// - self-test rising edge clears status latch
// - persisting fault wins over a clear; status stays set
// - terminal fault keeps status set against every clear until internal reset
// - self-test stimulus on while pin high
// - polarity bit picks positive or negative shift
// - freeze low: output follows each sample
// - freeze high: output data held
// - normal mode disables serial interface
// - new sample every 16us
`timescale 1ns/100ps
`include "ash_regs.svh"

module ash_ctrl
    import ash_pkg::*;
#(
    parameter int RST_HOLD_CYC = `ASH_RST_HOLD_CYC,
    parameter int HIZ_CYC      = `ASH_HIZ_CYC,
    parameter int STAB_CYC     = `ASH_STAB_CYC
)
(
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    // control pins
    input  wire logic        i_reset_n_pin,
    input  wire logic        i_sclk_pin,
    input  wire logic        i_self_test_pin,
    input  wire logic        i_sample_freeze_pin,
    // status pin
    output logic             o_status_o,
    output logic             o_status_oe,
    // processor side
    input  wire ash_fault_s  i_fault,
    input  wire ash_sample_s i_sample,
    input  wire logic        i_self_test_polarity_bit,
    input  wire logic        i_normal_mode,
    output logic             o_sample_tick,
    output ash_sample_s      o_accel,
    output logic             o_self_test_en,
    output logic             o_spi_en,
    output logic             o_int_reset
);

    // ----------------------------------------
    // constants and checks
    // ----------------------------------------
    localparam int SAMPLE_CYC = `ASH_SAMPLE_CYC;
    localparam int CW         = `ASH_CNT_W;

    generate
        if (RST_HOLD_CYC < 2 || RST_HOLD_CYC >= (1 << CW) || HIZ_CYC < 2
            || HIZ_CYC >= (1 << CW) || STAB_CYC < 2 || STAB_CYC >= (1 << CW))
        begin : g_bad_count
            $error("phase count parameter out of range");
        end
    endgenerate

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    wire  logic [3:0] pins_raw;
    logic [3:0]       sync1_r;
    logic [3:0]       sync2_r;
    logic [3:0]       prev_r;

    assign pins_raw = {i_sample_freeze_pin, i_self_test_pin, i_sclk_pin, i_reset_n_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_sync
            always_ff @(posedge i_ref_clk or posedge i_sys_rst)
            begin
                if (i_sys_rst)
                begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    prev_r[gi]  <= 1'b0;
                end
                else
                begin
                    sync1_r[gi] <= pins_raw[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    prev_r[gi]  <= sync2_r[gi];
                end
            end
        end
    endgenerate

    wire logic rstn_s;
    wire logic sclk_s;
    wire logic st_s;
    wire logic frz_s;
    wire logic st_rise;

    assign rstn_s  = sync2_r[`ASH_PIN_IDX_RSTN];
    assign sclk_s  = sync2_r[`ASH_PIN_IDX_SCLK];
    assign st_s    = sync2_r[`ASH_PIN_IDX_ST];
    assign frz_s   = sync2_r[`ASH_PIN_IDX_FRZ];
    assign st_rise = st_s & ~prev_r[`ASH_PIN_IDX_ST];

    // ----------------------------------------
    // two-pin reset detector
    // ----------------------------------------
    logic [CW-1:0] hold_cnt_r;
    logic [CW-1:0] hold_cnt_nxt;
    logic          int_rst_r;
    wire  logic    hold_cond;
    wire  logic    hold_done;

    assign hold_cond = ~rstn_s & sclk_s;
    assign hold_done = hold_cond && (hold_cnt_r == CW'(RST_HOLD_CYC - 1));
    assign hold_cnt_nxt = !hold_cond ? '0 :
                          (hold_cnt_r == CW'(RST_HOLD_CYC)) ? hold_cnt_r :
                          hold_cnt_r + 1'b1;

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            hold_cnt_r <= '0;
            int_rst_r  <= 1'b0;
        end
        else
        begin
            hold_cnt_r <= hold_cnt_nxt;
            int_rst_r  <= hold_done;
        end
    end

    assign o_int_reset = int_rst_r;

    // ----------------------------------------
    // status phases and latch
    // ----------------------------------------
    ash_state_e    state_r;
    ash_state_e    state_nxt;
    logic [CW-1:0] phase_cnt_r;
    logic [CW-1:0] phase_cnt_nxt;
    logic          status_r;
    logic          status_nxt;
    logic          term_r;
    wire  logic    fault_any;
    wire  logic    hiz_end;
    wire  logic    stab_end;

    assign fault_any = i_fault.parity | i_fault.over_temp | i_fault.clk_freq
                     | i_fault.terminal | term_r;
    assign hiz_end   = (state_r == ASH_ST_HIZ) && (phase_cnt_r == CW'(HIZ_CYC - 1));
    assign stab_end  = (state_r == ASH_ST_STAB) && (phase_cnt_r == CW'(STAB_CYC - 1));

    always_comb
    begin
        state_nxt     = state_r;
        phase_cnt_nxt = phase_cnt_r + 1'b1;
        status_nxt    = status_r;
        case (state_r)
            ASH_ST_HIZ:
            begin
                status_nxt = 1'b1;
                if (hiz_end)
                begin
                    state_nxt     = ASH_ST_STAB;
                    phase_cnt_nxt = '0;
                end
            end
            ASH_ST_STAB:
            begin
                status_nxt = 1'b1;
                if (stab_end)
                begin
                    state_nxt     = ASH_ST_RUN;
                    phase_cnt_nxt = '0;
                end
            end
            ASH_ST_RUN:
            begin
                phase_cnt_nxt = '0;
                if (fault_any)
                    status_nxt = 1'b1;
                else if (st_rise)
                    status_nxt = 1'b0;
            end
            default:
            begin
                state_nxt     = ASH_ST_HIZ;
                phase_cnt_nxt = '0;
                status_nxt    = 1'b1;
            end
        endcase
        if (int_rst_r)
        begin
            state_nxt     = ASH_ST_HIZ;
            phase_cnt_nxt = '0;
            status_nxt    = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_r     <= ASH_ST_HIZ;
            phase_cnt_r <= '0;
            status_r    <= `ASH_STATUS_RST;
            term_r      <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            phase_cnt_r <= phase_cnt_nxt;
            status_r    <= status_nxt;
            term_r      <= (term_r & ~int_rst_r) | i_fault.terminal;
        end
    end

    assign o_status_o  = status_r;
    assign o_status_oe = (state_r != ASH_ST_HIZ);

    // ----------------------------------------
    // sample period, self-test and freeze
    // ----------------------------------------
    localparam int SW = $clog2(SAMPLE_CYC);

    logic [SW-1:0] smp_cnt_r;
    logic          tick_r;
    ash_sample_s   accel_r;
    ash_sample_s   stim_smp;
    wire  logic    smp_wrap;
    wire  logic    [`ASH_AXIS_W-1:0] st_off;

    assign smp_wrap = (smp_cnt_r == SW'(SAMPLE_CYC - 1));
    assign st_off   = `ASH_ST_OFFSET;

    always_comb
    begin
        stim_smp = i_sample;
        if (st_s)
        begin
            if (i_self_test_polarity_bit)
            begin
                stim_smp.x = i_sample.x - $signed(st_off);
                stim_smp.y = i_sample.y - $signed(st_off);
            end
            else
            begin
                stim_smp.x = i_sample.x + $signed(st_off);
                stim_smp.y = i_sample.y + $signed(st_off);
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            smp_cnt_r <= '0;
            tick_r    <= 1'b0;
            accel_r   <= '0;
        end
        else
        begin
            smp_cnt_r <= smp_wrap ? '0 : smp_cnt_r + 1'b1;
            tick_r    <= smp_wrap;
            if (tick_r && !frz_s)
                accel_r <= stim_smp;
        end
    end

    assign o_sample_tick  = tick_r;
    assign o_accel        = accel_r;
    assign o_self_test_en = st_s;
    assign o_spi_en       = ~i_normal_mode;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    a_reset_detect_fire: assert property (
        hold_done |=> o_int_reset ##1 (state_r == ASH_ST_HIZ) && !o_status_oe)
        else $error("held reset pins did not restart status");

    a_hiz_undriven: assert property (
        hiz_end |-> !o_status_oe ##1 (o_status_oe && o_status_o) || o_int_reset)
        else $error("status not driven high after hiz phase");

    a_stab_start: assert property (
        $rose(o_status_oe) |-> (state_r == ASH_ST_STAB) && (phase_cnt_r == '0))
        else $error("stabilization did not start with status");

    a_stab_no_clear: assert property (
        (state_r == ASH_ST_STAB) && st_rise |=> o_status_o)
        else $error("status cleared during stabilization");

    a_clear_on_edge: assert property (
        (state_r == ASH_ST_RUN) && st_rise && !fault_any && !o_int_reset |=> !o_status_o)
        else $error("self-test edge did not clear status");

    a_set_wins: assert property (
        (state_r == ASH_ST_RUN) && fault_any |=> o_status_o)
        else $error("fault lost against clear");

    a_terminal_sticky: assert property (
        $rose(term_r) |-> o_status_o [*3])
        else $error("terminal fault did not keep status");

    a_freeze_hold: assert property (
        frz_s |=> $stable(o_accel))
        else $error("output changed while frozen");

    a_tick_period: assert property (
        o_sample_tick |=> !o_sample_tick [*8])
        else $error("sample tick too close");

    a_edge_single: assert property (
        st_rise |=> !st_rise)
        else $error("rising edge longer than one cycle");

    a_selftest_follow: assert property (
        $rose(i_self_test_pin) |-> ##2 o_self_test_en)
        else $error("self-test not enabled after pin rise");

endmodule

// [tb/ash_host_model.sv]
// system controller model: drives the control pins, watches status
// assumes the bench clock; pins change on falling edges only
`timescale 1ns/100ps

module ash_host_model
(
    // clock
    input  wire logic i_ref_clk,
    // control pins
    output logic      o_reset_n_pin,
    output logic      o_sclk_pin,
    output logic      o_self_test_pin,
    output logic      o_sample_freeze_pin,
    // status pin
    input  wire logic i_status_pin
);
    // ------
    // pin tasks
    // ------
    initial
    begin
        o_reset_n_pin       = 1'b1;
        o_sclk_pin          = 1'b0;
        o_self_test_pin     = 1'b0;
        o_sample_freeze_pin = 1'b0;
    end

    // reset request: both levels held n cycles
    task automatic pin_reset(input int n);
        @(negedge i_ref_clk);
        o_reset_n_pin = 1'b0;
        o_sclk_pin    = 1'b1;
        repeat (n) @(negedge i_ref_clk);
        o_reset_n_pin = 1'b1;
        o_sclk_pin    = 1'b0;
    endtask

    // clear request: low, then a rising edge held hi cycles
    task automatic clear_edge(input int hi);
        @(negedge i_ref_clk);
        o_self_test_pin = 1'b0;
        repeat (3) @(negedge i_ref_clk);
        o_self_test_pin = 1'b1;
        repeat (hi) @(negedge i_ref_clk);
        o_self_test_pin = 1'b0;
    endtask

    task automatic set_pins(input logic st, input logic frz);
        @(negedge i_ref_clk);
        o_self_test_pin     = st;
        o_sample_freeze_pin = frz;
    endtask
endmodule

// [tb/accel_status_hold_control_tb_top.sv]
// bench for the status/hold control with a sample model
// assumes short counts set on the design parameters
`timescale 1ns/100ps
`include "ash_regs.svh"

module accel_status_hold_control_tb_top
    import ash_pkg::*;
;
    localparam int RH = 20;
    localparam int HZ = 10;
    localparam int SB = 20;
    logic        clk, rst, rstn_p, sclk_p, st_p, frz_p, st_o, st_oe;
    logic        pol, nm, tick, st_en, spi_en, int_rst, pend, frz_m, st_m, mon_on;
    logic [3:0]  fault_v;
    ash_sample_s smp, accel, exp_s, held_s;
    wire         status_w = st_oe ? st_o : 1'bz;
    int          num_errors, comparisons, gap, nrst, c;
    int          seed = 23368;
    logic [2:0]  tbl [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6, 3'h0};

    ash_ctrl #(.RST_HOLD_CYC(RH), .HIZ_CYC(HZ), .STAB_CYC(SB)) dut_u (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_reset_n_pin(rstn_p), .i_sclk_pin(sclk_p),
        .i_self_test_pin(st_p), .i_sample_freeze_pin(frz_p), .o_status_o(st_o),
        .o_status_oe(st_oe), .i_fault(ash_fault_s'(fault_v)), .i_sample(smp),
        .i_self_test_polarity_bit(pol), .i_normal_mode(nm), .o_sample_tick(tick),
        .o_accel(accel), .o_self_test_en(st_en), .o_spi_en(spi_en), .o_int_reset(int_rst));

    ash_host_model host_u (.i_ref_clk(clk), .o_reset_n_pin(rstn_p), .o_sclk_pin(sclk_p),
        .o_self_test_pin(st_p), .o_sample_freeze_pin(frz_p), .i_status_pin(status_w));

    // ------
    // helpers
    // ------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1)
        begin
            $display("CHECK FAILED %0t %s", $time, msg);
            num_errors++;
        end
    endtask

    task automatic conclude;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wait_lvl(ref logic s, input logic v, input int n, output int k);
        for (k = 0; k < n && s !== v; k++)
            @(negedge clk);
        if (s !== v)
        begin
            chk(1'b0, "timeout");
            conclude();
        end
    endtask

    function automatic ash_sample_s calc(ash_sample_s s);
        int          off;
        ash_sample_s r;
        off = st_m ? (pol ? -int'(`ASH_ST_OFFSET) : int'(`ASH_ST_OFFSET)) : 0;
        r.x = 16'(int'(s.x) + off);
        r.y = 16'(int'(s.y) + off);
        return r;
    endfunction

    // ------
    // sample model
    // ------
    always @(negedge clk)
    begin
        if (int_rst === 1'b1)
            nrst++;
        if (pend)
            chk(accel === exp_s, "accel data");
        pend = mon_on && tick === 1'b1;
        smp = $random(seed);
        if (pend && !frz_m)
            held_s = calc(smp);
        exp_s = held_s;
        if (pend)
        begin
            if (gap > 0)
                chk(gap == `ASH_SAMPLE_CYC, "tick period");
            gap = 1;
        end
        else if (gap > 0)
            gap++;
    end

    task automatic start_phase(input int lo);
        wait_lvl(st_oe, 1'b1, HZ + 20, c);
        chk(c >= lo && c <= HZ + 3, "hiz length");
        chk(st_o === 1'b1 && host_u.i_status_pin === 1'b1, "status high after hiz");
        host_u.clear_edge(4);
        chk(st_o === 1'b1, "clear in stabilization");
        repeat (SB) @(negedge clk);
        host_u.clear_edge(4);
        chk(st_o === 1'b0, "clear after stabilization");
    endtask

    // ------
    // main sequence
    // ------
    initial
    begin
        rst = 1'b1; nm = 1'b0; pol = 1'b0; fault_v = 4'h0; held_s = '0;
        mon_on = 1'b0; frz_m = 1'b0; st_m = 1'b0; pend = 1'b0; gap = 0; nrst = 0;
        repeat (2) @(negedge clk);
        chk(spi_en === 1'b1, "spi on outside normal mode");
        chk(st_oe === 1'b0 && st_o === 1'b1, "status in reset");
        rst = 1'b0;
        nm = 1'b1;
        @(negedge clk);
        chk(spi_en === 1'b0, "spi off in normal mode");
        start_phase(HZ - 2);
        for (int i = 1; i < 4; i++)
        begin
            fault_v[i] = 1'b1;
            repeat (2) @(negedge clk);
            chk(st_o === 1'b1, "fault sets status");
            host_u.clear_edge(4);
            chk(st_o === 1'b1, "persisting fault");
            fault_v[i] = 1'b0;
            host_u.clear_edge(4);
            chk(st_o === 1'b0, "clear after fault");
        end
        mon_on = 1'b1;
        wait_lvl(tick, 1'b1, 2000, c);
        for (int k = 0; k < 6; k++)
        begin
            host_u.set_pins(tbl[k][1], tbl[k][2]);
            {frz_m, st_m, pol} = tbl[k];
            repeat (4) @(negedge clk);
            chk(st_en === st_m, "self-test enable");
            wait_lvl(tick, 1'b1, 2000, c);
        end
        repeat (2) @(negedge clk);
        mon_on = 1'b0;
        fault_v[0] = 1'b1;
        @(negedge clk);
        fault_v[0] = 1'b0;
        host_u.clear_edge(4);
        chk(st_o === 1'b1, "terminal fault");
        host_u.pin_reset(RH - 5);
        repeat (5) @(negedge clk);
        chk(nrst == 0, "short hold ignored");
        host_u.pin_reset(RH + 4);
        chk(nrst == 1, "one reset pulse");
        chk(!st_oe && st_o && host_u.i_status_pin === 1'bz, "status after reset");
        start_phase(1);
        conclude();
    end
endmodule
